// ---- rtl/edc_ctrl.sv ----
/*
 * configuration, modes, diagnostics and parity of a 64-bit edc unit.
 * assumes all pins synchronous to clk; the diagnostic capture clock
 * is sampled as an ordinary input and its rising edge detected.
 */
`timescale 1ns/1ps
`default_nettype none
module edc_ctrl (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [63:0] system_data_bus_in,
   output logic      [63:0] system_data_bus_out,
   output logic             system_data_bus_oe,
   input  wire logic        system_output_request,
   input  wire logic [7:0]  parity_bus_in,
   output logic      [7:0]  parity_bus_out,
   output logic             parity_bus_oe,
   input  wire logic [63:0] memory_data_bus_in,
   input  wire logic [7:0]  memory_check_in,
   output logic      [63:0] memory_data_bus_out,
   output logic      [7:0]  memory_check_out,
   output logic             memory_data_bus_oe,
   input  wire logic        mem_read_strobe,
   input  wire logic        mem_write_strobe,
   input  wire logic [7:0]  lane_merge_select,
   input  wire logic        config_write_enable_n,
   input  wire logic        diag_capture_clock,
   output logic             fault_flag_n,
   output logic             multi_fault_flag_n,
   output logic             parity_fault_flag_n,
   output logic             buffer_depth_config
);
   // ***************************************************
   // registers and wires
   // ***************************************************
   logic [15:0]         cfg_reg;
   logic [7:0]          inject_reg;
   logic [63:0]         rd_data_reg;
   logic [7:0]          rd_cb_reg;
   logic                diag_clk_q_reg;
   edc_pkg::mode_e      mode;
   logic                clear_on;
   logic                psel;
   logic                rback;
   logic                check_on;
   logic                correct_on;
   logic                inject_load;
   logic [7:0]          core_check;
   logic [7:0]          core_syn;
   logic                core_err;
   logic                core_multi;
   logic [63:0]         core_data;
   logic [37:0]         diag_word;
   logic [63:0]         sd_next;
   logic [63:0]         wr_src;
   logic [63:0]         merged;
   logic [7:0]          par_mis;
   logic                md_write;

   diag_if dg ();

   // ***************************************************
   // configuration decode
   // ***************************************************

   assign mode      = edc_pkg::mode_e'(cfg_reg[edc_pkg::MODE_LSB +: edc_pkg::MODE_W]);
   assign clear_on  = cfg_reg[edc_pkg::CLEAR_BIT];
   assign psel      = cfg_reg[edc_pkg::PSEL_BIT];
   assign rback     = cfg_reg[edc_pkg::RBACK_BIT];

   // detection in modes 2 to 4
   assign check_on   = (mode == edc_pkg::MODE_DETECT) ||
                       (mode == edc_pkg::MODE_NORMAL) ||
                       (mode == edc_pkg::MODE_INJECT);
   assign correct_on = (mode == edc_pkg::MODE_NORMAL);

   // inject load on a write cycle
   assign inject_load = mem_write_strobe && (mode == edc_pkg::MODE_INJECT);
   assign md_write    = mem_write_strobe && (mode != edc_pkg::MODE_INJECT);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg <= edc_pkg::CFG_RESET;
      end else if (!config_write_enable_n) begin
         cfg_reg <= system_data_bus_in[15:0];
      end
   end

   // ***************************************************
   // read latches and error core
   // ***************************************************

   // memory word and checkbits latched on a read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_reg <= 64'h0;
         rd_cb_reg   <= edc_pkg::ZERO_CB;
      end else if (mem_read_strobe) begin
         rd_data_reg <= memory_data_bus_in;
         rd_cb_reg   <= memory_check_in;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         inject_reg <= 8'h00;
      end else if (inject_load) begin
         inject_reg <= system_data_bus_in[7:0];
      end
   end

   assign core_check = (mode == edc_pkg::MODE_INJECT) ? inject_reg : rd_cb_reg;

   edc_core u_core (
      .data       (rd_data_reg),
      .check      (core_check),
      .correct_en (correct_on),
      .syndrome   (core_syn),
      .err        (core_err),
      .multi      (core_multi),
      .corrected  (core_data)
   );

   // ***************************************************
   // diagnostic capture
   // ***************************************************

   // sampled capture clock, edge found here
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         diag_clk_q_reg <= 1'b0;
      end else begin
         diag_clk_q_reg <= diag_capture_clock;
      end
   end

   assign dg.capture = diag_capture_clock && !diag_clk_q_reg;
   assign dg.clear   = clear_on;
   assign dg.err     = check_on && core_err;
   assign dg.multi   = core_multi;
   assign dg.syn     = core_syn;
   assign dg.cb      = core_check;
   assign dg.word    = rd_data_reg;

   diag_log u_log (
      .clk   (clk),
      .rst_n (rst_n),
      .dg    (dg.log)
   );

   // ***************************************************
   // system side output
   // ***************************************************

   assign diag_word = {dg.syn2_reg, dg.cls_reg, dg.cnt_reg,
                       dg.syn1_reg, dg.cb_reg, inject_reg};

   assign sd_next = rback ? {48'h0, cfg_reg} :
                    (mode == edc_pkg::MODE_ERRDATA) ? dg.word_reg :
                    (mode == edc_pkg::MODE_DIAG) ? {{edc_pkg::DIAG_PAD_W{1'b0}}, diag_word} :
                    core_data;

   // system bus and read parity
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         system_data_bus_out <= 64'h0;
         system_data_bus_oe  <= 1'b0;
         parity_bus_out      <= 8'h00;
         parity_bus_oe       <= 1'b0;
      end else begin
         system_data_bus_out <= sd_next;
         system_data_bus_oe  <= system_output_request;
         parity_bus_out      <= edc_pkg::byte_par(sd_next, psel);
         parity_bus_oe       <= system_output_request;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_flag_n       <= 1'b1;
         multi_fault_flag_n <= 1'b1;
      end else begin
         fault_flag_n       <= !(check_on && core_err);
         multi_fault_flag_n <= !(check_on && core_multi);
      end
   end

   // ***************************************************
   // memory side write
   // ***************************************************

   // mode 0 sources the error word, zero after clear
   assign wr_src = (mode == edc_pkg::MODE_ERRDATA) ? dg.word_reg : system_data_bus_in;

   // byte merge, selected lanes from the system side
   genvar g;
   generate
      for (g = 0; g < edc_pkg::LANES; g++) begin : g_lane
         assign merged[8*g +: 8] = lane_merge_select[g] ? wr_src[8*g +: 8] : rd_data_reg[8*g +: 8];
      end
   endgenerate

   // only lanes from the system bus count
   assign par_mis = (edc_pkg::byte_par(system_data_bus_in, psel) ^ parity_bus_in) & lane_merge_select;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         memory_data_bus_out <= 64'h0;
         memory_check_out    <= edc_pkg::ZERO_CB;
         memory_data_bus_oe  <= 1'b0;
      end else begin
         memory_data_bus_oe <= md_write;
         if (md_write) begin
            memory_data_bus_out <= merged;
            memory_check_out    <= edc_pkg::gen_cb(merged);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         parity_fault_flag_n <= 1'b1;
         buffer_depth_config <= 1'b0;
      end else begin
         parity_fault_flag_n <= !(mem_write_strobe && (|par_mis));
         buffer_depth_config <= cfg_reg[edc_pkg::DEPTH_BIT];
      end
   end

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb_c @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_cfg_write_load: assert property (!config_write_enable_n
      |=> cfg_reg == $past(system_data_bus_in[15:0])) else $error("config not loaded");
   a_readback_out: assert property (rback
      |=> system_data_bus_out == {48'h0, $past(cfg_reg)}) else $error("readback wrong");
   a_errdata_out: assert property (!rback && mode == edc_pkg::MODE_ERRDATA
      |=> system_data_bus_out == $past(dg.word_reg)) else $error("error word not shown");
   a_diag_layout: assert property (!rback && mode == edc_pkg::MODE_DIAG
      |=> system_data_bus_out[15:8] == $past(dg.cb_reg)
          && system_data_bus_out[27:24] == $past(dg.cnt_reg)) else $error("diag layout wrong");
   a_zero_check: assert property (md_write && wr_src == 64'h0 && lane_merge_select == 8'hff
      |=> memory_check_out == 8'h0c) else $error("zero word checkbits wrong");
   a_parity_gen: assert property (##1 parity_bus_out[0]
      == ((^system_data_bus_out[7:0]) ^ $past(psel))) else $error("parity bit wrong");
   a_parity_fault: assert property (mem_write_strobe && (|par_mis)
      |=> !parity_fault_flag_n) else $error("parity fault missed");
   a_inject_flag: assert property (mode == edc_pkg::MODE_INJECT && core_err
      |=> !fault_flag_n) else $error("injected mismatch not flagged");

   // mode outputs, latch, depth and flag checks
   a_detect_pass: assert property (!rback && mode == edc_pkg::MODE_DETECT
      |=> system_data_bus_out == $past(rd_data_reg)) else $error("detect mode changed data");
   a_inject_load: assert property (inject_load
      |=> inject_reg == $past(system_data_bus_in[7:0])) else $error("inject latch not loaded");
   a_depth_copy: assert property (##1 buffer_depth_config
      == $past(cfg_reg[edc_pkg::DEPTH_BIT])) else $error("depth bit not exported");
   a_parity_clean: assert property (mem_write_strobe && par_mis == 8'h00
      |=> parity_fault_flag_n) else $error("false parity fault");
   a_quiet_flags: assert property (!check_on
      |=> fault_flag_n && multi_fault_flag_n) else $error("flag outside detect modes");
endmodule // edc_ctrl
`default_nettype wire

// ---- shared/edc_pkg.sv ----
/*
 * constants, mode codes and code functions of the edc control block.
 * assumes a 64-bit data word protected by 8 checkbits.
 */
`default_nettype none
package edc_pkg;
   localparam int DATA_W = 64;
   localparam int CB_W   = 8;
   localparam int LANES  = 8;
   // configuration register layout
   localparam int CFG_W      = 16;
   localparam int MODE_LSB   = 0;
   localparam int MODE_W     = 3;
   localparam int CLEAR_BIT  = 3;
   localparam int DEPTH_BIT  = 4;
   localparam int PSEL_BIT   = 5;
   localparam int RBACK_BIT  = 6;
   localparam logic [15:0] CFG_RESET = 16'h0003;
   // checkbits of an all-zero word
   localparam logic [7:0] ZERO_CB = 8'h0c;
   // diagnostic values
   localparam logic [3:0] CNT_MAX    = 4'hf;
   localparam logic [1:0] CLS_SINGLE = 2'h1;
   localparam logic [1:0] CLS_MULTI  = 2'h2;
   localparam int DIAG_PAD_W = 26;

   typedef enum logic [2:0] {
      MODE_ERRDATA = 3'b000,
      MODE_DIAG    = 3'b001,
      MODE_DETECT  = 3'b010,
      MODE_NORMAL  = 3'b011,
      MODE_INJECT  = 3'b100
   } mode_e;

   // odd-weight column of data bit i
   function automatic logic [7:0] col_code(input int i);
      int n;
      n = 0;
      col_code = 8'h00;
      for (int k = 3; k < 128; k++) begin
         if ((k & (k - 1)) != 0) begin
            if (n == i) col_code[6:0] = 7'(k);
            n++;
         end
      end
      col_code[7] = ~^col_code[6:0];
   endfunction

   function automatic logic [7:0] gen_cb(input logic [63:0] d);
      gen_cb = ZERO_CB;
      for (int i = 0; i < DATA_W; i++) begin
         if (d[i]) gen_cb = gen_cb ^ col_code(i);
      end
   endfunction

   function automatic logic [7:0] byte_par(input logic [63:0] d, input logic odd);
      for (int i = 0; i < LANES; i++) begin
         byte_par[i] = (^d[8*i +: 8]) ^ odd;
      end
   endfunction
endpackage
`default_nettype wire

// ---- shared/diag_if.sv ----
/*
 * carrier between the control top and the diagnostic log.
 * assumes one clock domain, owned by the modules on either side.
 */
`timescale 1ns/1ps
`default_nettype none
interface diag_if;
   logic        capture;
   logic        clear;
   logic        err;
   logic        multi;
   logic [7:0]  syn;
   logic [7:0]  cb;
   logic [63:0] word;
   logic [7:0]  cb_reg;
   logic [7:0]  syn1_reg;
   logic [7:0]  syn2_reg;
   logic [3:0]  cnt_reg;
   logic [1:0]  cls_reg;
   logic [63:0] word_reg;
   modport src (output capture, clear, err, multi, syn, cb, word,
                input cb_reg, syn1_reg, syn2_reg, cnt_reg, cls_reg, word_reg);
   modport log (input capture, clear, err, multi, syn, cb, word,
                output cb_reg, syn1_reg, syn2_reg, cnt_reg, cls_reg, word_reg);
endinterface
`default_nettype wire

// ---- rtl/edc_core.sv ----
/*
 * syndrome, error classing and single-bit correction.
 * assumes data and checkbits come from registers upstream.
 */
`timescale 1ns/1ps
`default_nettype none
module edc_core (
   input  wire logic [63:0] data,
   input  wire logic [7:0]  check,
   input  wire logic        correct_en,
   output logic      [7:0]  syndrome,
   output logic             err,
   output logic             multi,
   output logic      [63:0] corrected
);
   logic [63:0] flip;
   logic        cb_only;

   assign syndrome = edc_pkg::gen_cb(data) ^ check;
   assign err      = |syndrome;

   // locate the failing data bit
   genvar g;
   generate
      for (g = 0; g < 64; g++) begin : g_loc
         assign flip[g] = (syndrome == edc_pkg::col_code(g));
      end
   endgenerate

   // a single checkbit error has a one-hot syndrome
   assign cb_only = err && ((syndrome & (syndrome - 8'h01)) == 8'h00);
   assign multi   = err && !cb_only && !(|flip);
   assign corrected = correct_en ? (data ^ flip) : data;
endmodule // edc_core
`default_nettype wire

// ---- rtl/diag_log.sv ----
/*
 * the six diagnostic registers of the edc block.
 * assumes capture is a one-cycle pulse per rising diagnostic clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module diag_log (
   input  wire logic clk,
   input  wire logic rst_n,
   diag_if.log       dg
);
   logic first_done_reg;
   logic hit;
   logic first_hit;

   assign hit       = dg.capture && dg.err;
   assign first_hit = hit && !first_done_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_done_reg <= 1'b0;
         dg.cb_reg      <= 8'h00;
         dg.syn1_reg    <= 8'h00;
         dg.syn2_reg    <= 8'h00;
         dg.cnt_reg     <= 4'h0;
         dg.cls_reg     <= 2'h0;
         dg.word_reg    <= 64'h0;
      end else if (dg.clear) begin
         // clear is a level and wins over a capture in the same cycle
         first_done_reg <= 1'b0;
         dg.cb_reg      <= 8'h00;
         dg.syn1_reg    <= 8'h00;
         dg.syn2_reg    <= 8'h00;
         dg.cnt_reg     <= 4'h0;
         dg.cls_reg     <= 2'h0;
         dg.word_reg    <= 64'h0;
      end else begin
         if (first_hit) begin
            first_done_reg <= 1'b1;
            dg.cb_reg      <= dg.cb;
            dg.syn1_reg    <= dg.syn;
            dg.cls_reg     <= dg.multi ? edc_pkg::CLS_MULTI : edc_pkg::CLS_SINGLE;
            dg.word_reg    <= dg.word;
         end
         if (hit) begin
            dg.syn2_reg <= dg.syn;
            if (dg.cnt_reg != edc_pkg::CNT_MAX) dg.cnt_reg <= dg.cnt_reg + 4'h1;
         end
      end
   end

   default clocking cb_d @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_count_step: assert property (hit && !dg.clear && dg.cnt_reg != 4'hf
      |=> dg.cnt_reg == $past(dg.cnt_reg) + 4'h1) else $error("error count did not step");
   a_first_hold: assert property (first_done_reg && !dg.clear && !$past(dg.clear)
      |=> $stable(dg.word_reg) && $stable(dg.syn1_reg)) else $error("first error data changed");
   a_clear_zero: assert property (dg.clear
      |=> dg.cnt_reg == 4'h0 && dg.word_reg == 64'h0) else $error("clear left data behind");
endmodule // diag_log
`default_nettype wire

// ---- tb/mem_model.sv ----
/*
 * one-word model of the checkbit-protected memory array.
 * assumes the bench commands bit flips on reads.
 */
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   input  wire logic        clk,
   input  wire logic [63:0] wr_data,
   input  wire logic [7:0]  wr_check,
   input  wire logic        wr_oe,
   input  wire logic        rd_strobe,
   input  wire logic [63:0] flip_data,
   input  wire logic [7:0]  flip_check,
   output logic      [63:0] rd_data,
   output logic      [7:0]  rd_check
);
   logic [63:0] word_reg;
   logic [7:0]  cb_reg;
   // store merged word and checkbits while the device drives the bus
   always_ff @(posedge clk) begin
      if (wr_oe) begin
         word_reg <= wr_data;
         cb_reg   <= wr_check;
      end
   end
   // answer reads with flips; idle bus shows the inverse pattern
   assign rd_data  = rd_strobe ? (word_reg ^ flip_data) : ~word_reg;
   assign rd_check = rd_strobe ? (cb_reg ^ flip_check) : ~cb_reg;
endmodule // mem_model
`default_nettype wire

// ---- tb/edc_mode_diag_parity_control_tb.sv ----
/*
 * self-checking bench of the edc control block.
 * assumes edc_ctrl and mem_model; inputs driven on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
module edc_mode_diag_parity_control_tb;
   logic        clk, rst_n, sreq, cfg_n, dcap, rstb, wstb;
   logic [63:0] sd_in, sd_out, md_out, md_in, flip_d;
   logic [7:0]  p_in, p_out, cb_in, cb_out, lanes, flip_c;
   logic        sd_oe, p_oe, md_oe, f_n, m_n, pf_n, depth;
   int          error_cnt, check_count, cyc;
   localparam logic [63:0] D = 64'h0123_4567_89ab_cdef;
   // ****************************************
   // clock, reset and instances
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   edc_ctrl dut (.clk(clk), .rst_n(rst_n), .system_data_bus_in(sd_in), .system_data_bus_out(sd_out),
      .system_data_bus_oe(sd_oe), .system_output_request(sreq), .parity_bus_in(p_in),
      .parity_bus_out(p_out), .parity_bus_oe(p_oe), .memory_data_bus_in(md_in),
      .memory_check_in(cb_in), .memory_data_bus_out(md_out), .memory_check_out(cb_out),
      .memory_data_bus_oe(md_oe), .mem_read_strobe(rstb), .mem_write_strobe(wstb),
      .lane_merge_select(lanes), .config_write_enable_n(cfg_n), .diag_capture_clock(dcap),
      .fault_flag_n(f_n), .multi_fault_flag_n(m_n), .parity_fault_flag_n(pf_n),
      .buffer_depth_config(depth));
   mem_model mem (.clk(clk), .wr_data(md_out), .wr_check(cb_out), .wr_oe(md_oe), .rd_strobe(rstb),
      .flip_data(flip_d), .flip_check(flip_c), .rd_data(md_in), .rd_check(cb_in));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // per-byte parity worked out by the bench
   function automatic logic [7:0] par(input logic [63:0] d, input logic odd);
      for (int i = 0; i < 8; i++) begin
         par[i] = (^d[8*i +: 8]) ^ odd;
      end
   endfunction
   // config write, returns once readback has settled
   task automatic cfg_wr(input logic [15:0] v);
      @(negedge clk);
      cfg_n = 1'b0;
      sd_in = {48'h0, v};
      @(negedge clk);
      cfg_n = 1'b1;
      repeat (2) @(negedge clk);
   endtask
   // memory read, returns after flags and data land
   task automatic mem_rd(input logic [63:0] fd, input logic [7:0] fc);
      @(negedge clk);
      rstb   = 1'b1;
      flip_d = fd;
      flip_c = fc;
      @(negedge clk);
      rstb = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   // memory write, returns in the cycle of the answer
   task automatic mem_wr(input logic [63:0] d, input logic [7:0] l, input logic [7:0] p);
      @(negedge clk);
      wstb  = 1'b1;
      sd_in = d;
      lanes = l;
      p_in  = p;
      @(negedge clk);
      wstb = 1'b0;
   endtask
   task automatic capture;
      @(negedge clk);
      dcap = 1'b1;
      @(negedge clk);
      dcap = 1'b0;
      @(negedge clk);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_config;
      check(cb_out, 8'h0c);
      cfg_wr(16'h0053);
      check(sd_out[15:0], 16'h0053);
      check(depth, 1'b1);
      cfg_wr(16'h0003);
      check(depth, 1'b0);
      // output enables follow the request one edge late
      @(negedge clk);
      sreq = 1'b0;
      repeat (2) @(negedge clk);
      check({sd_oe, p_oe}, 2'b00);
      sreq = 1'b1;
      repeat (2) @(negedge clk);
      check({sd_oe, p_oe}, 2'b11);
      $display("test config done");
   endtask
   task automatic t_init;
      // clear, mode 0, all lanes selected
      cfg_wr(16'h0008);
      check(sd_out, 64'h0);
      mem_wr(64'hffff_ffff_ffff_ffff, 8'hff, 8'h00);
      check(md_out, 64'h0);
      check(cb_out, 8'h0c);
      check(md_oe, 1'b1);
      $display("test init done");
   endtask
   task automatic t_inject;
      cfg_wr(16'h0004);
      mem_wr(64'h0c, 8'hff, 8'h00);
      mem_rd(64'h0, 8'h00);
      check({f_n, m_n}, 2'b11);
      mem_wr(64'h0d, 8'hff, 8'h01);
      mem_rd(64'h0, 8'h00);
      check(f_n, 1'b0);
      cfg_wr(16'h0001);
      check(sd_out[7:0], 8'h0d);
      $display("test inject done");
   endtask
   task automatic t_parity;
      cfg_wr(16'h0023);
      mem_wr(D, 8'hfb, par(D, 1'b1) ^ 8'h04);
      check(pf_n, 1'b1);
      mem_wr(D, 8'hff, par(D, 1'b1) ^ 8'h04);
      check(pf_n, 1'b0);
      mem_wr(D, 8'hff, par(D, 1'b1));
      check(pf_n, 1'b1);
      mem_rd(64'h0, 8'h00);
      check(sd_out, D);
      check(p_out, par(D, 1'b1));
      $display("test parity done");
   endtask
   task automatic t_modes;
      cfg_wr(16'h0002);
      mem_rd(64'h1, 8'h00);
      check(f_n, 1'b0);
      check(sd_out, D ^ 64'h1);
      cfg_wr(16'h0003);
      mem_rd(64'h1, 8'h00);
      check(sd_out, D);
      check({f_n, m_n}, 2'b01);
      $display("test modes done");
   endtask
   task automatic t_diag;
      cfg_wr(16'h000b);
      cfg_wr(16'h0003);
      mem_rd(64'h0, 8'h01);
      check({f_n, m_n}, 2'b01);
      capture();
      mem_rd(64'h0, 8'h03);
      check(m_n, 1'b0);
      capture();
      cfg_wr(16'h0001);
      check(sd_out[37:16], {8'h03, 2'h1, 4'h2, 8'h01});
      check(sd_out[15:8], mem.cb_reg ^ 8'h01);
      check(sd_out[63:38], 26'h0);
      cfg_wr(16'h0000);
      check(sd_out, D);
      cfg_wr(16'h0003);
      repeat (14) begin
         mem_rd(64'h0, 8'h05);
         capture();
      end
      cfg_wr(16'h0001);
      check(sd_out[37:16], {8'h05, 2'h1, 4'hf, 8'h01});
      cfg_wr(16'h0009);
      check(sd_out[37:8], 30'h0);
      cfg_wr(16'h0008);
      check(sd_out, 64'h0);
      $display("test diag done");
   endtask
   // ****************************************
   // main sequence and timeout
   // ****************************************
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         wrap_up();
      end
   end
   initial begin
      {rst_n, cfg_n, dcap, rstb, wstb} = 5'b01000;
      sreq = 1'b1;
      {sd_in, flip_d} = '0;
      {p_in, lanes, flip_c} = '0;
      error_cnt = 0;
      check_count = 0;
      cyc = 0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      t_config();
      t_init();
      t_inject();
      t_parity();
      t_modes();
      t_diag();
      wrap_up();
   end
endmodule // edc_mode_diag_parity_control_tb
`default_nettype wire
